/* File: logic/adc_calib_average_control.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "adc_cal_map.svh"

// Behaviour
// - Writing one to calibrate-go starts the self-calibration sequence.
// - Calibrate-go reads one while calibrating; hardware clears it at the end.
// - Any register write during calibration invalidates it and sets the fail flag.
// - Starting calibration aborts any conversion in progress.
// - Calibration fails on hardware trigger select, a register write, or stop mode.
// - Writing one clears the fail flag; writing zero leaves it.
// - Fail flag reads zero after a good calibration, one after a failed one.
// - Continuous off: one conversion or one averaged set per initiation, then stop.
// - Continuous on: keep converting single results or sets until reconfigured.
// - Average-enable turns hardware averaging on and off.
// - Count select 00/01/10/11 averages 4/8/16/32 conversions.
// - Control bits 31:8 and 5:4 read zero and ignore writes.
// - Trigger select one: start on hardware trigger after select pulse; zero: software.
module adc_calib_average_control #(
    parameter int unsigned CAL_CYCLES = `CAL_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_n_i,
    // Register port
    input  wire adc_cal_pkg::reg_addr_t reg_addr_i,
    input  wire adc_cal_pkg::reg_data_t reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output adc_cal_pkg::reg_data_t      reg_rdata_o,
    // Hardware trigger and power state
    input  wire logic                   hw_trig_sel_i,
    input  wire logic                   hw_trig_i,
    input  wire logic                   stop_mode_i,
    // Conversion engine
    input  wire logic                   conv_done_i,
    input  wire adc_cal_pkg::sample_t   conv_data_i,
    output logic                        conv_start_o,
    output logic                        conv_abort_o,
    // Status
    output logic                        cal_busy_o,
    output logic                        irq_o
);
    import adc_cal_pkg::*;

    // Control and status state.
    conv_state_t state_r;
    conv_state_t state_nxt;
    logic        cont_r;
    logic        avg_en_r;
    logic [1:0]  avg_sel_r;
    logic        calibration_fail_flag_r;
    logic        calibration_fail_flag_nxt;
    logic        trig_sel_r;
    logic        hw_trig_d_r;
    logic [2:0]  irq_status_r;
    logic [2:0]  irq_status_nxt;
    logic [2:0]  irq_mask_r;
    logic [2:0]  irq_mask_nxt;

    // Output flops.
    reg_data_t   rdata_r;
    logic        conv_start_r;
    logic        conv_start_nxt;
    logic        conv_abort_r;
    logic        cal_busy_r;
    logic        irq_r;

    // Submodule results.
    sample_t     avg_result;
    logic        acc_last;
    logic        acc_done;
    logic        cal_expired;

    // Address decode.
    wire hit_start  = (reg_addr_i == `OFS_CONV_START);
    wire hit_result = (reg_addr_i == `OFS_RESULT);
    wire hit_trig   = (reg_addr_i == `OFS_TRIG_CTRL);
    wire hit_ctrl   = (reg_addr_i == `OFS_CAL_AVG_CTRL);
    wire hit_status = (reg_addr_i == `OFS_IRQ_STATUS);
    wire hit_mask   = (reg_addr_i == `OFS_IRQ_MASK);

    wire wr_start   = reg_wr_i && hit_start;
    wire wr_trig    = reg_wr_i && hit_trig;
    wire wr_ctrl    = reg_wr_i && hit_ctrl;
    wire wr_mask    = reg_wr_i && hit_mask;
    wire rd_status  = reg_rd_i && hit_status;

    // Sequencing conditions.
    wire in_cal     = (state_r == ST_CAL);
    wire in_conv    = (state_r == ST_CONV);
    wire cal_go_req = wr_ctrl && reg_wdata_i[`BIT_CAL_GO] && !in_cal;

    // Any write counts, including one to the control register itself, since
    // the sequence cannot tell a harmless write from one that moves a setting.
    wire cal_fail_evt = in_cal && (reg_wr_i || trig_sel_r || stop_mode_i);
    wire cal_ok_evt   = in_cal && cal_expired && !cal_fail_evt;
    wire calibration_fail_flag_clr     = wr_ctrl && reg_wdata_i[`BIT_CAL_FAIL];

    wire sw_start     = wr_start && !trig_sel_r;
    wire hw_arm       = trig_sel_r && hw_trig_sel_i;
    wire hw_rise      = hw_trig_i && !hw_trig_d_r;
    wire sample_take  = in_conv && conv_done_i;
    wire set_last     = sample_take && acc_last;

    // Count select 00 maps to four samples; disabled averaging takes one.
    wire [2:0] acc_log2 = avg_en_r ? ({1'b0, avg_sel_r} + `AVG_LOG2_BASE) : 3'h0;

    // Register read view.
    wire [31:0] ctrl_view = {24'h000000, in_cal, calibration_fail_flag_r, 2'h0,
                             cont_r, avg_en_r, avg_sel_r};
    wire [31:0] result_view = {16'h0000, avg_result};
    wire [31:0] trig_view   = {31'h00000000, trig_sel_r};
    wire [31:0] status_view = {29'h00000000, irq_status_r};
    wire [31:0] mask_view   = {29'h00000000, irq_mask_r};

    // Unmapped offsets read as zero.
    wire [31:0] rd_mux =
        hit_ctrl   ? ctrl_view :
        hit_result ? result_view :
        hit_trig   ? trig_view :
        hit_status ? status_view :
        hit_mask   ? mask_view :
                     32'h00000000;

    // Conversion and calibration sequencer.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (cal_go_req) begin
                    state_nxt = ST_CAL;
                end else if (sw_start) begin
                    state_nxt = ST_CONV;
                end else if (hw_arm) begin
                    state_nxt = ST_ARMED;
                end
            end
            // Clearing the trigger select while armed drops back to idle.
            ST_ARMED: begin
                if (cal_go_req) begin
                    state_nxt = ST_CAL;
                end else if (!trig_sel_r) begin
                    state_nxt = ST_IDLE;
                end else if (hw_rise) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (cal_go_req) begin
                    state_nxt = ST_CAL;
                end else if (set_last && !cont_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            // A failure ends the run at once; otherwise the timer expiry does.
            ST_CAL: begin
                if (cal_fail_evt || cal_expired) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // A new conversion is requested on entry and after every result while
    // the set or continuous run goes on.
    always_comb begin
        conv_start_nxt = 1'b0;
        if (state_nxt == ST_CONV) begin
            conv_start_nxt = !in_conv || conv_done_i;
        end
    end

    // Calibration fail flag: a failure in the same cycle beats a clear.
    always_comb begin
        calibration_fail_flag_nxt = calibration_fail_flag_r;
        if (calibration_fail_flag_clr || cal_ok_evt) begin
            calibration_fail_flag_nxt = 1'b0;
        end
        if (cal_fail_evt) begin
            calibration_fail_flag_nxt = 1'b1;
        end
    end

    // Interrupt status clears on read; events in the read cycle survive.
    always_comb begin
        irq_status_nxt = rd_status ? 3'h0 : irq_status_r;
        irq_status_nxt[`IRQ_CONV_DONE] = irq_status_nxt[`IRQ_CONV_DONE] | acc_done;
        irq_status_nxt[`IRQ_CAL_DONE]  = irq_status_nxt[`IRQ_CAL_DONE] | cal_ok_evt;
        irq_status_nxt[`IRQ_CAL_FAIL]  = irq_status_nxt[`IRQ_CAL_FAIL] | cal_fail_evt;
    end

    assign irq_mask_nxt = wr_mask ? reg_wdata_i[2:0] : irq_mask_r;

    // Next values of the output flops.
    wire        conv_abort_nxt = cal_go_req && in_conv;
    wire        cal_busy_nxt   = (state_nxt == ST_CAL);
    wire        irq_nxt        = |(irq_status_nxt & irq_mask_nxt);
    wire [31:0] rdata_nxt      = reg_rd_i ? rd_mux : 32'h00000000;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // The stored trigger level resets to the pin's idle low, so the release
    // of reset cannot look like a trigger edge.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hw_trig_d_r <= 1'b0;
        end else begin
            hw_trig_d_r <= hw_trig_i;
        end
    end

    // Control fields stay writable during calibration, but such a write
    // already marks the calibration as failed.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cont_r    <= 1'(`CTRL_RESET >> `BIT_CONT);
            avg_en_r  <= 1'b0;
            avg_sel_r <= 2'h0;
        end else if (wr_ctrl) begin
            cont_r    <= reg_wdata_i[`BIT_CONT];
            avg_en_r  <= reg_wdata_i[`BIT_AVG_EN];
            avg_sel_r <= reg_wdata_i[`FLD_AVG_SEL_HI:`FLD_AVG_SEL_LO];
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trig_sel_r <= `TRIG_RESET;
        end else if (wr_trig) begin
            trig_sel_r <= reg_wdata_i[`BIT_TRIG_SEL];
        end
    end

    // A fail event and a write-one clear in one cycle leave the flag set, so
    // software never loses a failure that it has not yet seen.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            calibration_fail_flag_r <= 1'b0;
        end else begin
            calibration_fail_flag_r <= calibration_fail_flag_nxt;
        end
    end

    // Status bits stay set until software reads the status register.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_status_r <= 3'h0;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask_r <= `IRQ_MASK_RESET;
        end else begin
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // Every output leaves straight from a flop, so the bus and the engine
    // never see glitches from the decode logic in front of it.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= conv_start_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_abort_r <= 1'b0;
        end else begin
            conv_abort_r <= conv_abort_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cal_busy_r <= 1'b0;
        end else begin
            cal_busy_r <= cal_busy_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Averaging; a partial set is dropped when calibration aborts it.
    sample_accumulator u_accumulator (
        .core_clk_i     (core_clk_i),
        .reset_n_i      (reset_n_i),
        .clear_i        (cal_go_req),
        .sample_valid_i (sample_take),
        .sample_i       (conv_data_i),
        .count_log2_i   (acc_log2),
        .last_o         (acc_last),
        .average_o      (avg_result),
        .done_o         (acc_done)
    );

    // Calibration run length.
    interval_timer #(
        .WIDTH (16)
    ) u_cal_timer (
        .core_clk_i   (core_clk_i),
        .reset_n_i    (reset_n_i),
        .load_i       (cal_go_req),
        .load_value_i (16'(CAL_CYCLES)),
        .clear_i      (cal_fail_evt),
        .expired_o    (cal_expired)
    );

    assign reg_rdata_o  = rdata_r;
    assign conv_start_o = conv_start_r;
    assign conv_abort_o = conv_abort_r;
    assign cal_busy_o   = cal_busy_r;
    assign irq_o        = irq_r;

endmodule : adc_calib_average_control

`default_nettype wire

/* File: include/adc_cal_map.svh */
`ifndef ADC_CAL_MAP_SVH
`define ADC_CAL_MAP_SVH

// Timing: calibration run length in microseconds and the clock rate.
`define CLK_FREQ_MHZ        125
`define CAL_TIME_US         100
`define CAL_CYCLES_DEF      (`CAL_TIME_US * `CLK_FREQ_MHZ)

// Register byte offsets.
`define OFS_CONV_START      8'h00
`define OFS_RESULT          8'h10
`define OFS_TRIG_CTRL       8'h20
`define OFS_CAL_AVG_CTRL    8'h24
`define OFS_IRQ_STATUS      8'h40
`define OFS_IRQ_MASK        8'h44

// Field positions of calib_average_control.
`define BIT_CAL_GO          7
`define BIT_CAL_FAIL        6
`define BIT_CONT            3
`define BIT_AVG_EN          2
`define FLD_AVG_SEL_HI      1
`define FLD_AVG_SEL_LO      0

// Field position of trigger_compare_control.
`define BIT_TRIG_SEL        0

// Interrupt status and mask bit positions.
`define IRQ_CONV_DONE       0
`define IRQ_CAL_DONE        1
`define IRQ_CAL_FAIL        2

// Reset values.
`define CTRL_RESET          8'h00
`define TRIG_RESET          1'b0
`define IRQ_MASK_RESET      3'h0

// Averaging: count select 00 maps to 2^2 samples.
`define AVG_LOG2_BASE       3'h2

`endif

/* File: include/adc_cal_pkg.sv */
`default_nettype none

package adc_cal_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_CAL   = 4'b1000
    } conv_state_t;

    typedef logic [7:0]  reg_addr_t;
    typedef logic [31:0] reg_data_t;
    typedef logic [15:0] sample_t;

endpackage : adc_cal_pkg

`default_nettype wire

/* File: logic/interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    // Control
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_value_i,
    input  wire logic             clear_i,
    // Status
    output logic                  expired_o
);

    logic [WIDTH-1:0] count_r;
    logic             expired_r;
    wire              last_tick = (count_r == WIDTH'(1)) && !load_i && !clear_i;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r   <= '0;
            expired_r <= 1'b0;
        end else begin
            expired_r <= last_tick;
            if (load_i) begin
                count_r <= load_value_i;
            end else if (clear_i) begin
                count_r <= '0;
            end else if (count_r != '0) begin
                count_r <= count_r - WIDTH'(1);
            end
        end
    end

    assign expired_o = expired_r;

endmodule : interval_timer

`default_nettype wire

/* File: logic/sample_accumulator.sv */
`timescale 1ns/1ps
`default_nettype none

module sample_accumulator (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_n_i,
    // Samples in
    input  wire logic                 clear_i,
    input  wire logic                 sample_valid_i,
    input  wire adc_cal_pkg::sample_t sample_i,
    input  wire logic [2:0]           count_log2_i,
    // Result out
    output logic                      last_o,
    output adc_cal_pkg::sample_t      average_o,
    output logic                      done_o
);
    import adc_cal_pkg::*;

    logic [20:0] sum_r;
    logic [5:0]  cnt_r;
    sample_t     average_r;
    logic        done_r;

    wire [5:0]  target  = 6'h01 << count_log2_i;
    wire        last    = (cnt_r == 6'(target - 6'h01));
    wire [20:0] sum_nxt = sum_r + {5'h00, sample_i};

    // Sum is wide enough for 32 full-scale samples, so the shift is exact.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sum_r     <= '0;
            cnt_r     <= '0;
            average_r <= '0;
            done_r    <= 1'b0;
        end else if (clear_i) begin
            sum_r  <= '0;
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= sample_valid_i && last;
            if (sample_valid_i && last) begin
                sum_r     <= '0;
                cnt_r     <= '0;
                average_r <= 16'(sum_nxt >> count_log2_i);
            end else if (sample_valid_i) begin
                sum_r <= sum_nxt;
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end

    assign last_o    = last;
    assign average_o = average_r;
    assign done_o    = done_r;

endmodule : sample_accumulator

`default_nettype wire

/* File: dv/adc_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_chk #(
    parameter int unsigned CAL_CYCLES = 20
) (
    // Clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_n_i,
    // Register port
    input  wire adc_cal_pkg::reg_addr_t reg_addr_i,
    input  wire adc_cal_pkg::reg_data_t reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire adc_cal_pkg::reg_data_t reg_rdata_o,
    // Trigger, power state and engine
    input  wire logic                   hw_trig_sel_i,
    input  wire logic                   hw_trig_i,
    input  wire logic                   stop_mode_i,
    input  wire logic                   conv_done_i,
    input  wire adc_cal_pkg::sample_t   conv_data_i,
    input  wire logic                   conv_start_o,
    input  wire logic                   conv_abort_o,
    input  wire logic                   cal_busy_o,
    input  wire logic                   irq_o
);
    import adc_cal_pkg::*;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Counting busy cycles catches a timer that never expires.
    logic [15:0] busy_cnt_r;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) busy_cnt_r <= '0;
        else if (cal_busy_o) busy_cnt_r <= busy_cnt_r + 16'h1;
        else busy_cnt_r <= '0;
    end

    sequence s_cal_go;
        reg_wr_i && reg_addr_i == 8'h24 && reg_wdata_i[7] && !cal_busy_o;
    endsequence
    sequence s_ctrl_rd;
        reg_rd_i && reg_addr_i == 8'h24;
    endsequence

    a_cal_go_start: assert property (s_cal_go |=> cal_busy_o)
        else $error("calibration did not start");
    a_busy_readback: assert property (s_ctrl_rd |=> reg_rdata_o[7] == $past(cal_busy_o))
        else $error("go bit readback differs from busy");
    a_busy_bound: assert property (busy_cnt_r <= CAL_CYCLES + 1)
        else $error("calibration runs too long");
    a_write_fails: assert property (cal_busy_o && reg_wr_i |=> !cal_busy_o)
        else $error("write did not end calibration");
    a_stop_fails: assert property (cal_busy_o && stop_mode_i |=> !cal_busy_o)
        else $error("stop mode did not end calibration");
    a_abort_cause: assert property (conv_abort_o |-> $past(reg_wr_i) && $past(reg_addr_i) == 8'h24)
        else $error("abort without calibrate write");
    a_no_conv_cal: assert property (cal_busy_o && $past(cal_busy_o) |-> !conv_start_o)
        else $error("conversion started during calibration");
    a_reserved_zero: assert property (s_ctrl_rd |=> reg_rdata_o[31:8] == 24'h0 && reg_rdata_o[5:4] == 2'h0)
        else $error("reserved control bits not zero");
    a_start_cause: assert property (conv_start_o |-> $past(reg_wr_i) || $past(conv_done_i) || $past(hw_trig_i))
        else $error("conversion start without cause");
endmodule : adc_ctrl_chk

bind adc_calib_average_control adc_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .hw_trig_sel_i(hw_trig_sel_i), .hw_trig_i(hw_trig_i),
    .stop_mode_i(stop_mode_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o), .cal_busy_o(cal_busy_o),
    .irq_o(irq_o));

`default_nettype wire

/* File: dv/tb_adc_calib_average_control.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_adc_calib_average_control;
    import adc_cal_pkg::*;
    localparam int unsigned CALC = 20;
    logic core_clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic hw_trig_sel_i = 1'b0, hw_trig_i = 1'b0, stop_mode_i = 1'b0, conv_done_i = 1'b0;
    reg_addr_t reg_addr_i = '0;
    reg_data_t reg_wdata_i = '0, reg_rdata_o;
    sample_t conv_data_i = '0;
    logic conv_start_o, conv_abort_o, cal_busy_o, irq_o;
    int num_errors = 0, checks_done = 0, cycles = 0, b, dly = 0;
    reg_data_t nstart = '0;

    adc_calib_average_control #(.CAL_CYCLES(CALC)) dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .hw_trig_sel_i(hw_trig_sel_i), .hw_trig_i(hw_trig_i),
        .stop_mode_i(stop_mode_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
        .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o), .cal_busy_o(cal_busy_o),
        .irq_o(irq_o));

    always #4 core_clk_i = ~core_clk_i;

    // Engine stand-in: alternating samples make any even set average to 16'h0101.
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        conv_done_i <= (dly == 1);
        if (conv_abort_o) dly <= 0;
        else if (conv_start_o) begin
            dly <= 6;
            nstart <= nstart + 32'h1;
            conv_data_i <= nstart[0] ? 16'h0103 : 16'h0100;
        end else if (dly != 0) dly <= dly - 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input reg_data_t seen, input reg_data_t exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rdc(input reg_addr_t a, input reg_data_t e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(reg_rdata_o, e);
    endtask : rdc

    task automatic wait_irq;
        int i;
        i = 0;
        while (irq_o !== 1'b1 && i < 2000) begin
            @(posedge core_clk_i);
            i++;
        end
        check(reg_data_t'(irq_o), 32'h1);
    endtask : wait_irq

    task automatic finish_test;
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test

    initial begin
        repeat (5) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        rdc(8'h24, 32'h0);
        wr(8'h44, 32'h7);
        wr(8'h24, 32'hFFFFFF3F);
        rdc(8'h24, 32'h0F);
        rdc(8'h80, 32'h0);
        wr(8'h24, 32'h0);
        wr(8'h00, 32'h0);
        wait_irq();
        repeat (20) @(posedge core_clk_i);
        check(nstart, 32'h1);
        rdc(8'h10, 32'h100);
        rdc(8'h40, 32'h1);
        for (int s = 0; s < 4; s++) begin
            b = nstart;
            wr(8'h24, 32'h4 | s);
            wr(8'h00, 32'h0);
            wait_irq();
            repeat (20) @(posedge core_clk_i);
            check(nstart - b, 32'h4 << s);
            rdc(8'h10, 32'h101);
            rdc(8'h40, 32'h1);
        end
        b = nstart;
        wr(8'h24, 32'h8);
        wr(8'h00, 32'h0);
        repeat (60) @(posedge core_clk_i);
        check(reg_data_t'(nstart - b > 5), 32'h1);
        wr(8'h24, 32'h0);
        repeat (20) @(posedge core_clk_i);
        b = nstart;
        repeat (30) @(posedge core_clk_i);
        check(nstart - b, 32'h0);
        rdc(8'h40, 32'h1);
        // Hardware trigger path: a software start must be ignored while trigger select is one.
        wr(8'h20, 32'h1);
        rdc(8'h20, 32'h1);
        b = nstart;
        wr(8'h00, 32'h0);
        repeat (10) @(posedge core_clk_i);
        check(nstart - b, 32'h0);
        hw_trig_sel_i <= 1'b1;
        @(posedge core_clk_i);
        hw_trig_sel_i <= 1'b0;
        hw_trig_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        check(nstart - b, 32'h1);
        hw_trig_i <= 1'b0;
        rdc(8'h40, 32'h1);
        wr(8'h24, 32'h80);
        repeat (5) @(posedge core_clk_i);
        rdc(8'h24, 32'h40);
        rdc(8'h40, 32'h4);
        wr(8'h24, 32'h40);
        rdc(8'h24, 32'h0);
        wr(8'h20, 32'h0);
        wr(8'h24, 32'h80);
        rdc(8'h24, 32'h80);
        wr(8'h20, 32'h0);
        rdc(8'h24, 32'h40);
        wr(8'h24, 32'h0);
        rdc(8'h24, 32'h40);
        wr(8'h24, 32'h40);
        rdc(8'h40, 32'h4);
        wr(8'h24, 32'h80);
        stop_mode_i <= 1'b1;
        @(posedge core_clk_i);
        stop_mode_i <= 1'b0;
        rdc(8'h24, 32'h40);
        wr(8'h24, 32'h40);
        rdc(8'h40, 32'h4);
        wr(8'h00, 32'h0);
        wr(8'h24, 32'h80);
        #1;
        check(reg_data_t'(conv_abort_o), 32'h1);
        rdc(8'h24, 32'h80);
        check(reg_data_t'(cal_busy_o), 32'h1);
        repeat (CALC + 5) @(posedge core_clk_i);
        rdc(8'h24, 32'h0);
        check(reg_data_t'(cal_busy_o), 32'h0);
        rdc(8'h40, 32'h2);
        check(reg_data_t'(irq_o), 32'h0);
        finish_test();
    end
endmodule : tb_adc_calib_average_control

`default_nettype wire
